// [shared/pcm_pkg.sv]
// Constants, state layout and bus states of the upper port pin mux.
// Assumes one clock, mclk, and a synchronous active-high reset.
//
// Function
// - Direction one floats pin, zero drives latch.
// - Direction read returns stored bits despite overrides.
// - Every pin is an input after reset.
// - Master SPI clock drives bit 3 when output.
// - Input bit 3 feeds external SPI clock.
// - I2C clock bit 3, data bit 4, peripheral wins.
// - I2C input levels follow SMBus select.
// - Input bit 4 feeds SPI data input.
// - Output bit 5 carries SPI data output.
// - Async USART transmit owns bit 6 output.
// - Sync USART clock on bit 6, master drives.
// - Async receive data comes from input bit 7.
// - Sync USART data on bit 7, transmit wins.
// - Don't-care functions take direction from peripheral.
// - Latch register reads back latched values, not pins.
package pcm_pkg;

   // Port width in bits.
   localparam int PCM_W = 8;

   // Byte offsets of the registers on the bus.
   localparam logic [3:0] PCM_OFS_PIN  = 4'h0;
   localparam logic [3:0] PCM_OFS_LAT  = 4'h4;
   localparam logic [3:0] PCM_OFS_DIR  = 4'h8;
   localparam logic [3:0] PCM_OFS_MODE = 4'hC;

   // Reset values of the software registers.
   localparam logic [7:0] PCM_LAT_RST  = 8'h00;
   localparam logic [7:0] PCM_DIR_RST  = 8'hFF;
   localparam logic [6:0] PCM_MODE_RST = 7'h00;

   // Field positions inside the mode register.
   localparam int PCM_M_SSP_EN  = 0;
   localparam int PCM_M_I2C     = 1;
   localparam int PCM_M_SPI_MST = 2;
   localparam int PCM_M_SMBUS   = 3;
   localparam int PCM_M_US_EN   = 4;
   localparam int PCM_M_US_SYNC = 5;
   localparam int PCM_M_US_MST  = 6;

   // Pins that the serial peripherals can take over.
   localparam int PCM_P_CLK  = 3;
   localparam int PCM_P_DIN  = 4;
   localparam int PCM_P_DOUT = 5;
   localparam int PCM_P_TX   = 6;
   localparam int PCM_P_RX   = 7;

   // Bus slave states, one-hot.
   typedef enum logic [1:0] {
      PCM_BUS_IDLE = 2'b01,
      PCM_BUS_ACK  = 2'b10
   } pcm_bus_e;

   // Whole state of the top module.
   typedef struct packed {
      pcm_bus_e   bus;
      logic [7:0] lat;
      logic [7:0] dir;
      logic [6:0] mode;
      logic [7:0] rdata;
      logic [7:0] p_out;
      logic [7:0] p_oe;
      logic       sck_in;
      logic       sdi;
      logic       scl_in;
      logic       sda_in;
      logic       clk_in;
      logic       rx;
      logic       smb;
   } pcm_state_s;

endpackage

// [hw/pcm_pad_mux.sv]
// One pin of the port: chooses driver and data between port and peripheral.
// Assumes all inputs are registered or stable within the clock cycle.
`timescale 1ns/1ns
module pcm_pad_mux
   import pcm_pkg::*;
(
   // Port side.
   input  wire logic dir,
   input  wire logic lat,
   // Peripheral side.
   input  wire logic per_data,
   input  wire logic per_force,
   input  wire logic per_oe,
   input  wire logic per_out,
   // Pad side.
   output logic      pad_oe,
   output logic      pad_out
);

   // A forced peripheral decides the driver, otherwise the direction bit does.
   always_comb begin
      if (per_force) begin
         pad_oe = per_oe;
      end else begin
         pad_oe = ~dir;
      end
   end

   // Peripheral data replaces the latch when the function owns the pin.
   always_comb begin
      if (per_data) begin
         pad_out = per_out;
      end else begin
         pad_out = lat;
      end
   end

endmodule

// [hw/pcm_top.sv]
// Upper port pin mux with its latch, direction and mode registers.
// Assumes an Avalon-MM master on mclk and pads resolved outside.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
module pcm_top
   import pcm_pkg::*;
(
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Pads.
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   // Mode bits for the peripherals.
   output logic      [6:0]  periph_mode,
   // SPI side of the serial port.
   input  wire logic        spi_sck_out,
   input  wire logic        spi_sdo,
   output logic             spi_sck_in,
   output logic             spi_sdi,
   // I2C side of the serial port.
   input  wire logic        i2c_scl_low,
   input  wire logic        i2c_sda_low,
   output logic             i2c_scl_in,
   output logic             i2c_sda_in,
   output logic             smbus_levels,
   // Enhanced USART side.
   input  wire logic        usart_tx,
   input  wire logic        usart_clk_out,
   input  wire logic        usart_data_out,
   input  wire logic        usart_data_oe,
   output logic             usart_clk_in,
   output logic             usart_rx
);

   // Reset image of the state.
   localparam pcm_state_s PCM_STATE_RST = '{
      bus:   PCM_BUS_IDLE,
      lat:   PCM_LAT_RST,
      dir:   PCM_DIR_RST,
      mode:  PCM_MODE_RST,
      default: '0
   };

   pcm_state_s q;      // Registered state.
   pcm_state_s next_q; // Next state.

   logic       spi_on;  // Serial port in SPI mode.
   logic       i2c_on;  // Serial port in I2C mode.
   logic       ua_on;   // USART in asynchronous mode.
   logic       us_on;   // USART in synchronous mode.
   logic [3:0] sel;     // One-hot register select.
   logic [7:0] pc_data; // Peripheral owns pin data.
   logic [7:0] pc_frc;  // Peripheral owns pin direction.
   logic [7:0] pc_oe;   // Peripheral driver enable.
   logic [7:0] pc_out;  // Peripheral pin data.
   logic [7:0] pad_oe;  // Muxed driver enable.
   logic [7:0] pad_out; // Muxed pin data.

   // Decodes a byte address into a one-hot register select.
   function automatic logic [3:0] reg_sel(input logic [3:0] a);
      logic [3:0] s;
      s = 4'h0;
      if (a == PCM_OFS_PIN) begin
         s = 4'h1;
      end else if (a == PCM_OFS_LAT) begin
         s = 4'h2;
      end else if (a == PCM_OFS_DIR) begin
         s = 4'h4;
      end else if (a == PCM_OFS_MODE) begin
         s = 4'h8;
      end
      return s;
   endfunction

   // Mode decode from the mode register.
   assign spi_on = q.mode[PCM_M_SSP_EN] & ~q.mode[PCM_M_I2C];
   assign i2c_on = q.mode[PCM_M_SSP_EN] & q.mode[PCM_M_I2C];
   assign ua_on  = q.mode[PCM_M_US_EN] & ~q.mode[PCM_M_US_SYNC];
   assign us_on  = q.mode[PCM_M_US_EN] & q.mode[PCM_M_US_SYNC];
   assign sel    = reg_sel(avs_address);

   // Per-pin ownership; untouched pins stay plain port pins.
   always_comb begin
      pc_data = 8'h00;
      pc_frc  = 8'h00;
      pc_oe   = 8'h00;
      pc_out  = 8'h00;
      if (spi_on) begin
         // Master clock beats the latch while bit 3 is an output.
         pc_data[PCM_P_CLK]  = q.mode[PCM_M_SPI_MST];
         pc_out[PCM_P_CLK]   = spi_sck_out;
         pc_data[PCM_P_DOUT] = 1'b1;
         pc_out[PCM_P_DOUT]  = spi_sdo;
      end else if (i2c_on) begin
         // Open-drain lines pull low only when the peripheral asks.
         pc_data[PCM_P_CLK] = 1'b1;
         pc_frc[PCM_P_CLK]  = 1'b1;
         pc_oe[PCM_P_CLK]   = i2c_scl_low;
         pc_data[PCM_P_DIN] = 1'b1;
         pc_frc[PCM_P_DIN]  = 1'b1;
         pc_oe[PCM_P_DIN]   = i2c_sda_low;
      end
      if (ua_on) begin
         // Transmit drives bit 6 whatever the direction bit says.
         pc_data[PCM_P_TX] = 1'b1;
         pc_frc[PCM_P_TX]  = 1'b1;
         pc_oe[PCM_P_TX]   = 1'b1;
         pc_out[PCM_P_TX]  = usart_tx;
      end else if (us_on) begin
         // Clock is driven as master and released as slave.
         pc_data[PCM_P_TX] = 1'b1;
         pc_frc[PCM_P_TX]  = 1'b1;
         pc_oe[PCM_P_TX]   = q.mode[PCM_M_US_MST];
         pc_out[PCM_P_TX]  = usart_clk_out;
         // Data direction follows the USART's own enable.
         pc_data[PCM_P_RX] = 1'b1;
         pc_frc[PCM_P_RX]  = 1'b1;
         pc_oe[PCM_P_RX]   = usart_data_oe;
         pc_out[PCM_P_RX]  = usart_data_out;
      end
   end

   // One mux per pin.
   for (genvar i = 0; i < PCM_W; i++) begin : g_pad
      pcm_pad_mux u_pad (
         .dir       (q.dir[i]),
         .lat       (q.lat[i]),
         .per_data  (pc_data[i]),
         .per_force (pc_frc[i]),
         .per_oe    (pc_oe[i]),
         .per_out   (pc_out[i]),
         .pad_oe    (pad_oe[i]),
         .pad_out   (pad_out[i])
      );
   end

   // Next state: bus slave, peripheral inputs and registered pads.
   always_comb begin
      next_q = q;
      case (q.bus)
         PCM_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_q.bus = PCM_BUS_ACK;
               // Read data is prepared one cycle ahead of the answer.
               if (sel[0]) begin
                  next_q.rdata = pin_in;
               end else if (sel[1]) begin
                  next_q.rdata = q.lat;
               end else if (sel[2]) begin
                  next_q.rdata = q.dir;
               end else if (sel[3]) begin
                  next_q.rdata = {1'b0, q.mode};
               end else begin
                  next_q.rdata = 8'h00;
               end
            end
         end
         PCM_BUS_ACK: begin
            next_q.bus = PCM_BUS_IDLE;
            // Writes land at the edge where the master sees the answer.
            if (avs_write && avs_byteenable[0]) begin
               if (sel[0] || sel[1]) begin
                  next_q.lat = avs_writedata[7:0];
               end else if (sel[2]) begin
                  next_q.dir = avs_writedata[7:0];
               end else if (sel[3]) begin
                  next_q.mode = avs_writedata[6:0];
               end
            end
         end
         default: begin
            next_q.bus = PCM_BUS_IDLE;
         end
      endcase
      // SPI input pins are passed on only while their direction lets them; I2C and sync clock inputs ignore direction.
      next_q.sck_in = spi_on & q.dir[PCM_P_CLK] & pin_in[PCM_P_CLK];
      next_q.sdi    = spi_on & q.dir[PCM_P_DIN] & pin_in[PCM_P_DIN];
      next_q.scl_in = i2c_on ? pin_in[PCM_P_CLK] : 1'b1;
      next_q.sda_in = i2c_on ? pin_in[PCM_P_DIN] : 1'b1;
      next_q.smb    = i2c_on & q.mode[PCM_M_SMBUS];
      next_q.clk_in = us_on & pin_in[PCM_P_TX];
      // In async mode receive idles high when the pin is not an input.
      if (ua_on) begin
         next_q.rx = q.dir[PCM_P_RX] ? pin_in[PCM_P_RX] : 1'b1;
      end else begin
         next_q.rx = pin_in[PCM_P_RX];
      end
      next_q.p_out = pad_out;
      next_q.p_oe  = pad_oe;
   end

   // State register with synchronous reset.
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= PCM_STATE_RST;
      end else begin
         q <= next_q;
      end
   end

   // Outputs.
   assign avs_waitrequest = (avs_read | avs_write) & (q.bus != PCM_BUS_ACK);
   assign avs_readdata    = {24'h00_0000, q.rdata};
   assign pin_out         = q.p_out;
   assign pin_oe          = q.p_oe;
   assign periph_mode     = q.mode;
   assign spi_sck_in      = q.sck_in;
   assign spi_sdi         = q.sdi;
   assign i2c_scl_in      = q.scl_in;
   assign i2c_sda_in      = q.sda_in;
   assign smbus_levels    = q.smb;
   assign usart_clk_in    = q.clk_in;
   assign usart_rx        = q.rx;

   // Checks on the pin routing and the register file.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // A completed read of a register.
   sequence s_rd(logic [3:0] ofs);
      avs_read && !avs_waitrequest && avs_address == ofs;
   endsequence

   // Pins are floating inputs just after reset.
   property p_reset_in;
      $fell(rst) |-> q.dir == PCM_DIR_RST ##1 pin_oe == 8'h00;
   endproperty
   a_reset_in: assert property (p_reset_in)
      else $error("Pins not inputs after reset.");

   // Low pins with no function follow direction and latch.
   property p_gpio;
      1 |=> pin_oe[2:0] == ~$past(q.dir[2:0]) && pin_out[2:0] == $past(q.lat[2:0]);
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("Plain pin does not follow direction and latch.");

   // Direction read returns the stored value.
   property p_rd_dir;
      s_rd(PCM_OFS_DIR) |-> avs_readdata[7:0] == q.dir;
   endproperty
   a_rd_dir: assert property (p_rd_dir)
      else $error("Direction read differs from stored value.");

   // Latch read returns the latch.
   property p_rd_lat;
      s_rd(PCM_OFS_LAT) |-> avs_readdata[7:0] == q.lat;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("Latch read differs from latch.");

   // Master SPI clock reaches bit 3.
   property p_spi_clk;
      spi_on && q.mode[PCM_M_SPI_MST] && !q.dir[PCM_P_CLK]
         |=> pin_oe[PCM_P_CLK] && pin_out[PCM_P_CLK] == $past(spi_sck_out);
   endproperty
   a_spi_clk: assert property (p_spi_clk)
      else $error("SPI clock not driven on bit 3.");

   // External SPI clock reaches the serial port.
   property p_spi_ck_in;
      spi_on && q.dir[PCM_P_CLK] |=> spi_sck_in == $past(pin_in[PCM_P_CLK]);
   endproperty
   a_spi_ck_in: assert property (p_spi_ck_in)
      else $error("External SPI clock not delivered.");

   // I2C lines are pulled low only on request.
   property p_i2c;
      i2c_on |=> pin_oe[PCM_P_CLK] == $past(i2c_scl_low)
         && pin_oe[PCM_P_DIN] == $past(i2c_sda_low) && !pin_out[PCM_P_DIN];
   endproperty
   a_i2c: assert property (p_i2c)
      else $error("I2C drive does not follow the peripheral.");

   // SPI data output on bit 5.
   property p_sdo;
      spi_on && !q.dir[PCM_P_DOUT] |=> pin_oe[PCM_P_DOUT]
         && pin_out[PCM_P_DOUT] == $past(spi_sdo);
   endproperty
   a_sdo: assert property (p_sdo)
      else $error("SPI data output missing on bit 5.");

   // Async transmit drives bit 6 whatever the direction.
   property p_tx;
      ua_on |=> pin_oe[PCM_P_TX] && pin_out[PCM_P_TX] == $past(usart_tx);
   endproperty
   a_tx: assert property (p_tx)
      else $error("Transmit not driven on bit 6.");

   // Sync data direction follows the USART once sync mode has held two cycles in a row.
   property p_sync_dt;
      us_on [*2] |=> pin_oe[PCM_P_RX] == $past(usart_data_oe);
   endproperty
   a_sync_dt: assert property (p_sync_dt)
      else $error("Sync data direction not from USART.");

endmodule

// [sim/pcm_periph_model.sv]
// Model of the serial peripherals and the external pin world around the pin mux.
// Assumes the bench sets the peripheral output levels and the far-end pin levels.
`timescale 1ns/1ns
module pcm_periph_model (
   // Pads from the mux.
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Far-end pin levels and peripheral output levels set by the bench.
   input  wire logic [7:0] ext,
   input  wire logic [7:0] per_lvl,
   // Resolved pin levels back to the mux.
   output logic      [7:0] pin_in,
   // Peripheral outputs.
   output logic            spi_sck_out,
   output logic            spi_sdo,
   output logic            i2c_scl_low,
   output logic            i2c_sda_low,
   output logic            usart_tx,
   output logic            usart_clk_out,
   output logic            usart_data_out,
   output logic            usart_data_oe
);
   // A driven pin shows the mux's value; a floating one shows the far end.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext[i];
      end
   end

   // Peripheral outputs only change when the bench commands it.
   assign spi_sck_out    = per_lvl[0];
   assign spi_sdo        = per_lvl[1];
   assign i2c_scl_low    = per_lvl[2];
   assign i2c_sda_low    = per_lvl[3];
   assign usart_tx       = per_lvl[4];
   assign usart_clk_out  = per_lvl[5];
   assign usart_data_out = per_lvl[6];
   assign usart_data_oe  = per_lvl[7];
endmodule

// [sim/test_port_c_upper_pin_mux.sv]
// Self-checking bench for the upper port pin mux.
// Assumes the mux ends each bus access by dropping waitrequest; no latency is presumed.
`timescale 1ns/1ns
module test_port_c_upper_pin_mux;
   import pcm_pkg::*;
   logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0]  pin_in, pin_out, pin_oe, ext, per_lvl, q;
   logic [6:0]  periph_mode;
   logic        spi_sck_out, spi_sdo, spi_sck_in, spi_sdi, i2c_scl_low, i2c_sda_low;
   logic        i2c_scl_in, i2c_sda_in, smbus_levels, usart_tx, usart_clk_out;
   logic        usart_data_out, usart_data_oe, usart_clk_in, usart_rx;
   int          failures, tests_run;

   pcm_top u_pcm_top (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_mode(periph_mode),
      .spi_sck_out(spi_sck_out), .spi_sdo(spi_sdo), .spi_sck_in(spi_sck_in),
      .spi_sdi(spi_sdi), .i2c_scl_low(i2c_scl_low), .i2c_sda_low(i2c_sda_low),
      .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in), .smbus_levels(smbus_levels),
      .usart_tx(usart_tx), .usart_clk_out(usart_clk_out), .usart_data_out(usart_data_out),
      .usart_data_oe(usart_data_oe), .usart_clk_in(usart_clk_in), .usart_rx(usart_rx));

   pcm_periph_model u_pcm_periph_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
      .per_lvl(per_lvl), .pin_in(pin_in), .spi_sck_out(spi_sck_out), .spi_sdo(spi_sdo),
      .i2c_scl_low(i2c_scl_low), .i2c_sda_low(i2c_sda_low), .usart_tx(usart_tx),
      .usart_clk_out(usart_clk_out), .usart_data_out(usart_data_out),
      .usart_data_oe(usart_data_oe));

   // Clock of 4 ns period.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Prints the verdict and ends the run.
   task automatic conclude();
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Compares one result and counts it.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus access, held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write     <= wr;
      avs_read      <= ~wr;
      // Waitrequest and read data are both taken at the same rising edge.
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         failures++;
      end
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Sets far-end levels and lets the registered outputs settle.
   task automatic st(input logic [7:0] p, input logic [7:0] x);
      @(posedge mclk);
      per_lvl <= p;
      ext     <= x;
      repeat (3) @(posedge mclk);
   endtask

   // Reset values and an unmapped read.
   task automatic t_reset();
      bus(0, PCM_OFS_LAT, 8'h00);   chk("lat", 8'h00, q);
      bus(0, PCM_OFS_DIR, 8'h00);   chk("dir", 8'hFF, q);
      bus(0, PCM_OFS_MODE, 8'h00);  chk("mode", 8'h00, q);
      bus(0, 4'h2, 8'h00);          chk("unmapped", 8'h00, q);
      chk("oe", 8'h00, pin_oe);
   endtask

   // Plain port use: latch, direction and pin reads.
   task automatic t_gpio();
      bus(1, PCM_OFS_LAT, 8'hA5);
      bus(1, PCM_OFS_DIR, 8'h00);
      st(8'h00, 8'h3C);
      chk("oe", 8'hFF, pin_oe);
      chk("out", 8'hA5, pin_out);
      bus(1, PCM_OFS_DIR, 8'hF0);
      st(8'h00, 8'h3C);
      chk("oe", 8'h0F, pin_oe);
      bus(0, PCM_OFS_PIN, 8'h00);   chk("pin", 8'h35, q);
      bus(0, PCM_OFS_LAT, 8'h00);   chk("lat", 8'hA5, q);
      bus(1, PCM_OFS_PIN, 8'h5A);
      bus(0, PCM_OFS_LAT, 8'h00);   chk("lat", 8'h5A, q);
   endtask

   // SPI as clock master, then as slave.
   task automatic t_spi();
      bus(1, PCM_OFS_DIR, 8'hD7);
      bus(1, PCM_OFS_MODE, 8'h05);
      st(8'h02, 8'h3C);
      // Clock low beats a latch bit of one; data high beats a latch bit of zero.
      chk("sck", 2'b10, {pin_oe[3], pin_out[3]});
      chk("sdo", 2'b11, {pin_oe[5], pin_out[5]});
      chk("sdi", 1'b1, spi_sdi);
      bus(0, PCM_OFS_DIR, 8'h00);   chk("dir", 8'hD7, q);
      bus(1, PCM_OFS_DIR, 8'hFF);
      bus(1, PCM_OFS_MODE, 8'h01);
      st(8'h01, 8'h08);
      chk("sck_in", 2'b01, {pin_oe[3], spi_sck_in});
      st(8'h01, 8'h00);
      chk("sck_in", 1'b0, spi_sck_in);
   endtask

   // I2C pins ignore direction and latch.
   task automatic t_i2c();
      bus(1, PCM_OFS_DIR, 8'h00);
      bus(1, PCM_OFS_MODE, 8'h0B);
      st(8'h04, 8'h10);
      chk("i2c_oe", 2'b01, pin_oe[4:3]);
      chk("scl", 1'b0, pin_out[3]);
      chk("i2c_in", 2'b10, {i2c_sda_in, i2c_scl_in});
      chk("smb", 1'b1, smbus_levels);
      bus(1, PCM_OFS_MODE, 8'h03);
      st(8'h08, 8'h08);
      chk("sda", 3'b100, {pin_oe[4], pin_out[4], smbus_levels});
   endtask

   // USART in asynchronous and synchronous modes.
   task automatic t_usart();
      bus(1, PCM_OFS_DIR, 8'hBF);
      bus(1, PCM_OFS_MODE, 8'h10);
      st(8'h00, 8'h80);
      chk("tx", 2'b10, {pin_oe[6], pin_out[6]});
      chk("rx", 1'b1, usart_rx);
      // A low receive pin must reach the USART, not only its idle level.
      st(8'h00, 8'h00);
      chk("rx_low", 1'b0, usart_rx);
      bus(1, PCM_OFS_MODE, 8'h70);
      st(8'hC0, 8'h00);
      chk("pmode", 7'h70, periph_mode);
      chk("ck", 2'b10, {pin_oe[6], pin_out[6]});
      chk("dt", 2'b11, {pin_oe[7], pin_out[7]});
      bus(1, PCM_OFS_DIR, 8'hFF);
      bus(1, PCM_OFS_MODE, 8'h30);
      st(8'h00, 8'h40);
      chk("ck_in", 3'b001, {pin_oe[7:6], usart_clk_in});
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      conclude();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      ext = 8'h00;
      per_lvl = 8'h00;
      failures = 0;
      tests_run = 0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_gpio();
      t_spi();
      t_i2c();
      t_usart();
      conclude();
   end
endmodule
